// [design/slhm_top.sv]
// link health monitor: watchdog, per-lane checksum alarm, SYNC error pulse, arrival capture
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "slhm_cfg.svh"
module slhm_top #(
  parameter int LANES = 2,
  parameter int AW = 12,
  parameter logic [32:0] WD_TH_1 = `SLHM_WD_TH_1,
  parameter logic [32:0] WD_TH_2 = `SLHM_WD_TH_2,
  parameter logic [32:0] WD_TH_3 = `SLHM_WD_TH_3,
  parameter logic [32:0] WD_TH_4 = `SLHM_WD_TH_4
) (
  input wire logic core_clk, // 50 MHz
  input wire logic rst_b, // async, active low
  input wire logic [AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic link_up_pin, // link up level, asynchronous
  input wire logic [LANES-1:0] mb_done, // multiblock finished, per lane
  input wire logic [LANES-1:0] mb_crc_err, // that multiblock had a checksum error
  input wire logic lanes_ready, // every lane ready
  input wire logic eb_release_try, // elastic buffer release attempt
  input wire logic [LANES*`SLHM_ARR_W-1:0] lane_arrival_time, // arrival per lane
  output logic phy_rx_reset, // one-cycle receiver reset
  output logic phy_pll_reset, // one-cycle PHY PLL reset
  output logic sync_n, // SYNC, low while asserted
  output logic [LANES-1:0] lane_check_fault, // per-lane alarm
  output logic link_enable, // link enable control
  output logic link_soft_reset, // link soft reset control
  output logic irq // level interrupt
);

  function automatic logic [32:0] wd_threshold(input logic [2:0] sel);
    case (sel)
      3'h1: wd_threshold = WD_TH_1;
      3'h2: wd_threshold = WD_TH_2;
      3'h3: wd_threshold = WD_TH_3;
      3'h4: wd_threshold = WD_TH_4;
      default: wd_threshold = 33'h0;
    endcase
  endfunction

  function automatic logic [4:0] wd_decrement(input logic [1:0] sel);
    case (sel)
      2'h0: wd_decrement = 5'h01;
      2'h1: wd_decrement = 5'h02;
      2'h2: wd_decrement = 5'h08;
      default: wd_decrement = 5'h10;
    endcase
  endfunction

  // 1, 2, 4, 8 errored multiblocks
  function automatic logic [3:0] trig_count(input logic [1:0] sel);
    trig_count = 4'h1 << sel;
  endfunction

  // 1, 4, 16, 64 clean multiblocks
  function automatic logic [6:0] clean_count(input logic [1:0] sel);
    clean_count = 7'h01 << {sel, 1'b0};
  endfunction

  slhm_pkg::slhm_wdog_s wdog_q;
  slhm_pkg::slhm_checksum_alarm_thresholds_s checksum_alarm_thresholds_q;
  slhm_pkg::slhm_rd_s rd;
  logic [7:0] epw_reg_q, arstat_rsvd_q;
  logic [2:0] int_en_q, int_stat_q, int_stat_d, int_clr, int_ev;
  logic [2:0] sync_cnt_q, sync_cnt_d;
  logic [32:0] wd_cnt_q, wd_th, wd_dec;
  logic link_sync1_q, link_up_q, wd_on, wd_hit, err_ev, arr_valid_q, capture, link_off;
  logic aw_got_q, w_got_q, wr_fire, wr_ok;
  logic [3:0] err_cnt_q [LANES];
  logic [6:0] clean_q [LANES];
  logic [LANES-1:0] fault_set, fault_clr;
  logic [`SLHM_ARR_W-1:0] arr_q [LANES];
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [9:0] wr_idx;

  // link up comes from a pin: two flops first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_sync1_q <= 1'b0;
      link_up_q <= 1'b0;
    end else begin
      link_sync1_q <= link_up_pin;
      link_up_q <= link_sync1_q;
    end
  end

  assign link_off = !link_enable || link_soft_reset;

  // ---------------- watchdog ----------------
  assign wd_th = wd_threshold(wdog_q.timeout_threshold_select);
  assign wd_dec = 33'(wd_decrement(wdog_q.uptime_decrement_select));
  assign wd_on = !link_off && (wd_th != 33'h0);
  assign wd_hit = wd_on && (wd_cnt_q >= wd_th);

  // every cycle is sampled, so short link-up episodes are seen too
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt_q <= 33'h0;
    end else if (!wd_on || wd_hit) begin
      wd_cnt_q <= 33'h0;
    end else if (!link_up_q || (|lane_check_fault)) begin
      wd_cnt_q <= wd_cnt_q + 33'h1;
    end else if (wd_cnt_q > wd_dec) begin
      wd_cnt_q <= wd_cnt_q - wd_dec;
    end else begin
      wd_cnt_q <= 33'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_rx_reset <= 1'b0;
      phy_pll_reset <= 1'b0;
    end else begin
      phy_rx_reset <= wd_hit;
      phy_pll_reset <= wd_hit && wdog_q.pll_reset_on_timeout;
    end
  end

  // ---------------- SYNC error pulse ----------------
  assign err_ev = !link_off && (|(mb_done & mb_crc_err));

  always_comb begin
    sync_cnt_d = sync_cnt_q;
    if (err_ev && (epw_reg_q[2:0] != 3'h0)) begin
      sync_cnt_d = epw_reg_q[2:0];
    end else if (sync_cnt_q != 3'h0) begin
      sync_cnt_d = sync_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_cnt_q <= 3'h0;
      sync_n <= 1'b1;
    end else begin
      sync_cnt_q <= sync_cnt_d;
      sync_n <= (sync_cnt_d == 3'h0);
    end
  end

  // ---------------- per-lane checksum alarm ----------------
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      fault_set[i] = !link_off && mb_done[i] && mb_crc_err[i] && !lane_check_fault[i] &&
        ((err_cnt_q[i] + 4'h1) >= trig_count(checksum_alarm_thresholds_q.fault_trigger_count));
      fault_clr[i] = !link_off && mb_done[i] && !mb_crc_err[i] &&
        ((clean_q[i] + 7'h01) >= clean_count(checksum_alarm_thresholds_q.clean_run_length));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LANES; i++) begin
        err_cnt_q[i] <= 4'h0;
        clean_q[i] <= 7'h00;
      end
      lane_check_fault <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (link_off) begin
          err_cnt_q[i] <= 4'h0;
          clean_q[i] <= 7'h00;
          lane_check_fault[i] <= 1'b0;
        end else if (mb_done[i] && mb_crc_err[i]) begin
          clean_q[i] <= 7'h00;
          if (err_cnt_q[i] != `SLHM_ERR_SAT) begin
            err_cnt_q[i] <= err_cnt_q[i] + 4'h1;
          end
          if (fault_set[i]) begin
            lane_check_fault[i] <= 1'b1;
          end
        end else if (fault_clr[i]) begin
          err_cnt_q[i] <= 4'h0;
          clean_q[i] <= 7'h00;
          lane_check_fault[i] <= 1'b0;
        end else if (mb_done[i]) begin
          clean_q[i] <= clean_q[i] + 7'h01;
        end
      end
    end
  end

  // ---------------- lane arrival capture ----------------
  assign capture = !link_off && lanes_ready && eb_release_try && !arr_valid_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arr_valid_q <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        arr_q[i] <= '0;
      end
    end else if (link_off) begin
      arr_valid_q <= 1'b0;
    end else if (capture) begin
      arr_valid_q <= 1'b1;
      for (int i = 0; i < LANES; i++) begin
        arr_q[i] <= lane_arrival_time[i*`SLHM_ARR_W +: `SLHM_ARR_W];
      end
    end
  end

  // ---------------- interrupts ----------------
  always_comb begin
    int_ev = 3'h0;
    int_ev[`SLHM_IRQ_WDOG_BIT] = wd_hit;
    int_ev[`SLHM_IRQ_FAULT_BIT] = |fault_set;
    int_ev[`SLHM_IRQ_ARR_BIT] = capture;
    int_clr = 3'h0;
    if (wr_fire && wstrb_q[0] && (wr_idx == `SLHM_IDX_ICLR)) begin
      int_clr = wdata_q[2:0];
    end
    // a new event wins over a clear in the same cycle
    int_stat_d = (int_stat_q & ~int_clr) | int_ev;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq <= |(int_stat_d & int_en_q);
    end
  end

  // ---------------- register writes ----------------
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_idx = 10'(awaddr_q[AW-1:2]);
  assign wr_ok = (wr_idx == `SLHM_IDX_WDOG) || (wr_idx == `SLHM_IDX_EPW) ||
    (wr_idx == `SLHM_IDX_CRC) || (wr_idx == `SLHM_IDX_ARSTAT) ||
    (wr_idx == `SLHM_IDX_LINK) || (wr_idx == `SLHM_IDX_ISTAT) ||
    (wr_idx == `SLHM_IDX_ICLR) || (wr_idx == `SLHM_IDX_IEN);

  // settings are taken at any time; software keeps the link disabled
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_q <= `SLHM_RST_WDOG;
      epw_reg_q <= `SLHM_RST_EPW;
      checksum_alarm_thresholds_q <= `SLHM_RST_CRC;
      arstat_rsvd_q <= 8'h00;
      link_enable <= 1'b0;
      link_soft_reset <= 1'b0;
      int_en_q <= 3'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      case (wr_idx)
        `SLHM_IDX_WDOG: wdog_q <= wdata_q[7:0];
        `SLHM_IDX_EPW: epw_reg_q <= wdata_q[7:0];
        `SLHM_IDX_CRC: checksum_alarm_thresholds_q <= wdata_q[7:0];
        `SLHM_IDX_ARSTAT: arstat_rsvd_q <= {wdata_q[7:1], 1'b0};
        `SLHM_IDX_LINK: begin
          link_enable <= wdata_q[`SLHM_LINK_EN_BIT];
          link_soft_reset <= wdata_q[`SLHM_LINK_SRST_BIT];
        end
        `SLHM_IDX_IEN: int_en_q <= wdata_q[2:0];
        default: ;
      endcase
    end
  end

  // ---------------- AXI4-Lite write channels ----------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= slhm_pkg::SLHM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? slhm_pkg::SLHM_RESP_OKAY : slhm_pkg::SLHM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------- AXI4-Lite read channels ----------------
  always_comb begin
    logic [9:0] idx;
    idx = 10'(s_axi_araddr[AW-1:2]);
    rd.resp = slhm_pkg::SLHM_RESP_OKAY;
    rd.data = 32'h0;
    case (idx)
      `SLHM_IDX_WDOG: rd.data[7:0] = wdog_q;
      `SLHM_IDX_EPW: rd.data[7:0] = epw_reg_q;
      `SLHM_IDX_CRC: rd.data[7:0] = checksum_alarm_thresholds_q;
      `SLHM_IDX_ARSTAT: rd.data[7:0] = arstat_rsvd_q | {7'h00, arr_valid_q};
      `SLHM_IDX_LINK: rd.data[1:0] = {link_soft_reset, link_enable};
      `SLHM_IDX_ISTAT: rd.data[2:0] = int_stat_q;
      `SLHM_IDX_ICLR: rd.data = 32'h0;
      `SLHM_IDX_IEN: rd.data[2:0] = int_en_q;
      default: begin
        rd.resp = slhm_pkg::SLHM_RESP_SLVERR;
        for (int i = 0; i < LANES; i++) begin
          if (idx == `SLHM_IDX_ARR0 + 10'(i)) begin
            rd.resp = slhm_pkg::SLHM_RESP_OKAY;
            rd.data[`SLHM_ARR_W-1:0] = arr_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= slhm_pkg::SLHM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd.data;
      s_axi_rresp <= rd.resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_pll_with_rx: assert property (
    wd_hit |=> phy_rx_reset && (phy_pll_reset == $past(wdog_q.pll_reset_on_timeout)))
    else $error("PLL reset does not follow its enable");
  a_uptime_decrement: assert property (
    (wd_on && !wd_hit && link_up_q && !(|lane_check_fault) && wd_cnt_q > wd_dec)
    |=> wd_cnt_q == $past(wd_cnt_q) - $past(wd_dec))
    else $error("watchdog decrement wrong");
  a_watchdog_off: assert property (
    (wdog_q.timeout_threshold_select == 3'h0) |=> (wd_cnt_q == 33'h0) && !phy_rx_reset)
    else $error("disabled watchdog still counts");
  a_expiry_resets: assert property (
    wd_hit |=> phy_rx_reset && (wd_cnt_q == 33'h0) ##1 !phy_rx_reset)
    else $error("expiry did not reset PHY and counter");
  a_sync_pulse_len: assert property (
    (err_ev && epw_reg_q[2:0] == 3'h2) |=> !sync_n ##1 (!sync_n || err_ev))
    else $error("SYNC pulse too short");
  a_sync_quiet: assert property (
    (epw_reg_q[2:0] == 3'h0 && sync_cnt_q == 3'h0) |=> sync_n)
    else $error("SYNC pulsed with width zero");
  a_clean_clears: assert property (
    fault_clr[0] |=> !lane_check_fault[0] && (err_cnt_q[0] == 4'h0))
    else $error("clean run did not clear alarm");
  a_fault_raise: assert property (
    fault_set[0] |=> lane_check_fault[0])
    else $error("alarm not raised at trigger count");
  a_arrival_valid: assert property (
    capture |=> arr_valid_q [*1] ##1 (arr_valid_q || $past(link_off)))
    else $error("arrival capture flag not set");
  a_arrival_clear: assert property (
    link_off |=> !arr_valid_q)
    else $error("arrival flag not cleared");
  a_down_increment: assert property (
    (wd_on && !wd_hit && !link_up_q) |=> wd_cnt_q == $past(wd_cnt_q) + 33'h1)
    else $error("watchdog increment wrong");

endmodule

// [design/slhm_cfg.svh]
// register map, field positions, reset values and counts of the link health monitor
`ifndef SLHM_CFG_SVH
`define SLHM_CFG_SVH

// register indices; byte address is four times the index
`define SLHM_IDX_WDOG 10'h124
`define SLHM_IDX_EPW 10'h127
`define SLHM_IDX_CRC 10'h128
`define SLHM_IDX_ARSTAT 10'h12C
`define SLHM_IDX_LINK 10'h100
`define SLHM_IDX_ISTAT 10'h101
`define SLHM_IDX_ICLR 10'h102
`define SLHM_IDX_IEN 10'h103
`define SLHM_IDX_ARR0 10'h140

// reset values
`define SLHM_RST_WDOG 8'h80
`define SLHM_RST_EPW 8'h00
`define SLHM_RST_CRC 8'h00
`define SLHM_RST_LINK 8'h00
`define SLHM_RST_IEN 8'h00

// bit positions
`define SLHM_LINK_EN_BIT 0
`define SLHM_LINK_SRST_BIT 1
`define SLHM_IRQ_WDOG_BIT 0
`define SLHM_IRQ_FAULT_BIT 1
`define SLHM_IRQ_ARR_BIT 2

// counts
`define SLHM_WD_TH_1 33'h0_0002_0000
`define SLHM_WD_TH_2 33'h0_0008_0000
`define SLHM_WD_TH_3 33'h1_0000_0000
`define SLHM_WD_TH_4 33'h0_0080_0000
`define SLHM_ERR_SAT 4'h8
`define SLHM_ARR_W 6

`endif

// [design/slhm_pkg.sv]
// types shared by the link health monitor
package slhm_pkg;

  typedef struct packed {
    logic pll_reset_on_timeout;
    logic rsvd6;
    logic [1:0] uptime_decrement_select;
    logic rsvd3;
    logic [2:0] timeout_threshold_select;
  } slhm_wdog_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] clean_run_length;
    logic [1:0] fault_trigger_count;
  } slhm_checksum_alarm_thresholds_s;

  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } slhm_rd_s;

  localparam logic [1:0] SLHM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SLHM_RESP_SLVERR = 2'h2;

endpackage

// [test/slhm_tx_model.sv]
// transmitter-side model: link level, multiblock ends, elastic buffer release
`timescale 1ns/1ps
`include "slhm_cfg.svh"
module slhm_tx_model #(
  parameter int LANES = 2
) (
  input wire logic core_clk, // clock
  output logic link_up_pin, // link up level
  output logic [LANES-1:0] mb_done, // multiblock end
  output logic [LANES-1:0] mb_crc_err, // checksum error flag
  output logic lanes_ready, // all lanes ready
  output logic eb_release_try, // release attempt
  output logic [LANES*`SLHM_ARR_W-1:0] lane_arrival_time // arrival times
);
  initial begin
    link_up_pin = 1'b0;
    mb_done = '0;
    mb_crc_err = '1;
    lanes_ready = 1'b0;
    eb_release_try = 1'b0;
    lane_arrival_time = '1;
  end
  task automatic set_link(input logic up);
    @(posedge core_clk);
    link_up_pin <= up;
  endtask
  // outside the pulse the flags carry the inverse, never a stale value
  task automatic send_mb(input logic [LANES-1:0] ln, input logic [LANES-1:0] err);
    @(posedge core_clk);
    mb_done <= ln;
    mb_crc_err <= err;
    @(posedge core_clk);
    mb_done <= '0;
    mb_crc_err <= ~err;
  endtask
  task automatic try_release(input logic [LANES*`SLHM_ARR_W-1:0] t);
    @(posedge core_clk);
    lanes_ready <= 1'b1;
    eb_release_try <= 1'b1;
    lane_arrival_time <= t;
    @(posedge core_clk);
    eb_release_try <= 1'b0;
    lane_arrival_time <= ~t;
  endtask
endmodule

// [test/serial_link_health_monitor_bench.sv]
// self-checking bench of the link health monitor
`timescale 1ns/1ps
`include "slhm_cfg.svh"
module serial_link_health_monitor_bench;
  localparam logic [1:0] resp_ok = slhm_pkg::SLHM_RESP_OKAY;
  localparam logic [1:0] resp_err = slhm_pkg::SLHM_RESP_SLVERR;
  logic core_clk = 1'b0;
  logic rst_b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic link_up_pin, lanes_ready, eb_release_try, phy_rx_reset, phy_pll_reset, sync_n;
  logic link_enable, link_soft_reset, irq, pll;
  logic [1:0] mb_done, mb_crc_err, lane_check_fault;
  logic [11:0] lane_arrival_time;
  int error_cnt = 0, n_compared = 0, cyc, k, low;
  int thr [3] = '{64, 128, 256};
  int dex [4] = '{1530, 2560, 8740, 12000};
  logic [7:0] sel [3] = '{8'h01, 8'h02, 8'h04};

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  slhm_top #(.WD_TH_1(33'h40), .WD_TH_2(33'h80), .WD_TH_3(33'h2EE0), .WD_TH_4(33'h100))
    dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_up_pin(link_up_pin),
    .mb_done(mb_done), .mb_crc_err(mb_crc_err), .lanes_ready(lanes_ready),
    .eb_release_try(eb_release_try), .lane_arrival_time(lane_arrival_time),
    .phy_rx_reset(phy_rx_reset), .phy_pll_reset(phy_pll_reset), .sync_n(sync_n),
    .lane_check_fault(lane_check_fault), .link_enable(link_enable),
    .link_soft_reset(link_soft_reset), .irq(irq));

  slhm_tx_model tx_u (.core_clk(core_clk), .link_up_pin(link_up_pin),
    .mb_done(mb_done), .mb_crc_err(mb_crc_err), .lanes_ready(lanes_ready),
    .eb_release_try(eb_release_try), .lane_arrival_time(lane_arrival_time));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic expire();
    error_cnt++;
    $display("[ERR] t=%0t got=%h exp=%h (no answer)", $time, 1'b0, 1'b1);
    conclude();
  endtask
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) expire();
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) expire();
    cmp(s_axi_rdata, ed);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // settings change only with the link disabled, then the link is enabled again
  task automatic set_cfg(input logic [9:0] idx, input logic [7:0] d);
    axi_wr(`SLHM_IDX_LINK, 8'h00, resp_ok);
    axi_wr(idx, d, resp_ok);
    axi_wr(`SLHM_IDX_LINK, 8'h01, resp_ok);
  endtask
  task automatic wait_rst(input int lim, output int c, output logic p);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (phy_rx_reset !== 1'b1 && c < lim);
    p = phy_pll_reset;
  endtask

  initial begin
    rst_b <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_araddr <= '0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    axi_rd(`SLHM_IDX_WDOG, 32'h80, resp_ok);
    axi_rd(`SLHM_IDX_EPW, 32'h0, resp_ok);
    axi_rd(`SLHM_IDX_CRC, 32'h0, resp_ok);
    axi_rd(10'h3FF, 32'h0, resp_err);
    axi_wr(10'h3FF, 8'h5A, resp_err);
    // low byte strobe off: write answered but ignored
    s_axi_wstrb <= 4'hE;
    axi_wr(`SLHM_IDX_EPW, 8'h05, resp_ok);
    s_axi_wstrb <= 4'hF;
    axi_rd(`SLHM_IDX_EPW, 32'h0, resp_ok);
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      set_cfg(`SLHM_IDX_EPW, 8'(k));
      axi_rd(`SLHM_IDX_EPW, 32'(k), resp_ok);
      tx_u.send_mb(2'h1, 2'h1);
      low = 0;
      repeat (12) begin
        @(posedge core_clk);
        if (sync_n === 1'b0) low++;
      end
      cmp_rng(low, k, k);
    end
    $display("test sync done");
    for (k = 0; k < 4; k++) begin
      set_cfg(`SLHM_IDX_CRC, 8'(k * 5));
      repeat ((1 << k) - 1) tx_u.send_mb(2'h3, 2'h1);
      @(posedge core_clk);
      cmp({30'h0, lane_check_fault}, 32'h0);
      tx_u.send_mb(2'h3, 2'h1);
      @(posedge core_clk);
      cmp({30'h0, lane_check_fault}, 32'h1);
      repeat ((1 << (2 * k)) - 1) tx_u.send_mb(2'h3, 2'h0);
      @(posedge core_clk);
      cmp({30'h0, lane_check_fault}, 32'h1);
      tx_u.send_mb(2'h3, 2'h0);
      @(posedge core_clk);
      cmp({30'h0, lane_check_fault}, 32'h0);
    end
    $display("test alarm done");
    for (k = 0; k < 3; k++) begin
      set_cfg(`SLHM_IDX_WDOG, sel[k] | (k > 0 ? 8'h80 : 8'h00));
      wait_rst(400, cyc, pll);
      cmp_rng(cyc, thr[k] - 4, thr[k] + 6);
      cmp({31'h0, pll}, {31'h0, k > 0});
      wait_rst(400, cyc, pll);
      cmp_rng(cyc, thr[k], thr[k] + 2);
    end
    for (k = 0; k < 2; k++) begin
      set_cfg(`SLHM_IDX_WDOG, 8'h80 | 8'(k * 5));
      wait_rst(700, cyc, pll);
      cmp_rng(cyc, 700, 700);
    end
    // long up time lets each decrement setting give its own figure
    for (k = 0; k < 4; k++) begin
      set_cfg(`SLHM_IDX_WDOG, 8'h83 | 8'(k << 4));
      wait_rst(11500, cyc, pll);
      cmp_rng(cyc, 11500, 11500);
      tx_u.set_link(1'b1);
      repeat (1030) @(posedge core_clk);
      tx_u.set_link(1'b0);
      wait_rst(13000, cyc, pll);
      cmp_rng(cyc, dex[k] - 20, dex[k] + 20);
      cmp({31'h0, pll}, 32'h1);
    end
    $display("test watchdog done");
    axi_wr(`SLHM_IDX_ARSTAT, 8'h00, resp_ok);
    set_cfg(`SLHM_IDX_IEN, 8'h04);
    axi_rd(`SLHM_IDX_ARSTAT, 32'h0, resp_ok);
    tx_u.try_release(12'hA95);
    axi_rd(`SLHM_IDX_ARSTAT, 32'h1, resp_ok);
    tx_u.try_release(12'h56A);
    axi_rd(`SLHM_IDX_ARR0, 32'h15, resp_ok);
    axi_rd(`SLHM_IDX_ARR0 + 10'h1, 32'h2A, resp_ok);
    cmp({31'h0, irq}, 32'h1);
    axi_wr(`SLHM_IDX_IEN, 8'h00, resp_ok);
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0);
    axi_wr(`SLHM_IDX_IEN, 8'h04, resp_ok);
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h1);
    axi_wr(`SLHM_IDX_ICLR, 8'h04, resp_ok);
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0);
    axi_rd(`SLHM_IDX_ISTAT, 32'h3, resp_ok);
    axi_wr(`SLHM_IDX_LINK, 8'h03, resp_ok);
    cmp({30'h0, link_soft_reset, link_enable}, 32'h3);
    axi_rd(`SLHM_IDX_ARSTAT, 32'h0, resp_ok);
    $display("test arrival done");
    // reset again in mid-run: controls, status and settings back to reset values
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    cmp({29'h0, irq, link_soft_reset, link_enable}, 32'h0);
    axi_rd(`SLHM_IDX_WDOG, 32'h80, resp_ok);
    axi_rd(`SLHM_IDX_ISTAT, 32'h0, resp_ok);
    $display("test second reset done");
    conclude();
  end
endmodule
